/* File: src/sfch_handshake.sv */
// Serial flow-control handshake block: presets, enquire/acknowledge replies, hardwire line, free-space answers.
// Assumes a receiver and transmitter on sys_clk, and a buffer consumer that pulses buf_consume per byte used.
//
// Contract
// RULE1 - Host sends an enquiry before each data block in enquire/acknowledge mode.
// RULE2 - Block-size command takes block size, enquiry code, acknowledgment code in order.
// RULE3 - Output-format command takes turnaround, trigger, echo terminate, terminator in order.
// RULE4 - Hardwire line is high from power-on.
// RULE5 - Hardwire line goes low when free space falls below block size.
// RULE6 - Hardwire line stays low until free space exceeds block size.
// RULE7 - Host transmits another block only while the hardwire line is high.
// RULE8 - Free-space query is answered with empty byte count; host compares to block.
// RULE9 - Buffer size, delays, trigger, echo, initiator, terminator are all configurable.
// RULE10 - Handshake select value 0 none, 1 Xon-Xoff, 2 enquire/acknowledge, 3 hardwire.
// RULE11 - Handshake select without parameter acts as value 0.
// RULE12 - Preset 1 loads turnaround 50, echo 10, term 13, response 17, delay 10, immediate 19.
// RULE13 - Preset 2 loads trigger 17, echo 10, term 13, enquiry 5, response 6.
// RULE14 - Presets 0 and 3 clear all delays and characters; first terminator 13. No preset here clears the initiator character.
// RULE15 - Every preset sets block 80, buffer 1024, second terminator 0, mode field.
// RULE16 - Reply waits the turnaround delay after the request.
// RULE17 - With a trigger set, reply waits until the trigger character arrives.
// RULE18 - Intercharacter delay precedes every reply character, added to turnaround first.
// RULE19 - Nonzero enquiry character enables enquiry; zero disables it.
// RULE20 - Acknowledgment is sent only when free space reaches block size.
// RULE21 - Host sends at most one block after each acknowledgment.
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module sfch_handshake
    import sfch_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYC_PER_MS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Register port
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    // Received characters and buffer use
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic buf_consume,
    input wire logic free_query,
    // Reply characters
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    // Handshake line and echo state
    output logic dtr,
    output logic echo_wait
);

    // ==========================================================
    // Configuration
    logic [MSW-1:0] turn_ms;
    logic [MSW-1:0] icd_ms;
    logic [7:0] trigger_chr;
    logic [7:0] echo_chr;
    logic [7:0] term1_chr;
    logic [7:0] term2_chr;
    logic [7:0] init_chr;
    logic [7:0] imm_chr;
    logic [7:0] enq_chr;
    logic [7:0] ack_chr;
    logic [SZW-1:0] block_size;
    logic [SZW-1:0] buf_size;
    logic [1:0] hs_mode;
    sfch_method_t method;
    logic [1:0] preset_val;

    assign preset_val = reg_wdata[PRESET_PARAM_BIT] ? reg_wdata[PRESET_VAL_LSB +: 2] : 2'h0; // RULE11

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            turn_ms <= MS_ZERO;
            icd_ms <= MS_ZERO;
            trigger_chr <= CHR_NUL;
            echo_chr <= CHR_NUL;
            term1_chr <= CHR_CR;
            term2_chr <= CHR_NUL;
            init_chr <= CHR_NUL;
            imm_chr <= CHR_NUL;
            enq_chr <= CHR_NUL;
            ack_chr <= CHR_NUL;
            block_size <= DEF_BLOCK;
            buf_size <= DEF_BUF_SIZE;
            hs_mode <= HS_MODE_OFF;
            method <= METH_NONE;
        end else if (reg_wr) begin
            unique case (reg_addr)
                REG_OUT_DELAY: turn_ms <= reg_wdata[MSW-1:0]; // RULE3
                REG_OUT_CHARS: begin
                    trigger_chr <= reg_wdata[LO_BYTE_LSB +: 8]; // RULE3
                    echo_chr <= reg_wdata[HI_BYTE_LSB +: 8]; // RULE3
                end
                REG_OUT_TERM: begin
                    term1_chr <= reg_wdata[LO_BYTE_LSB +: 8]; // RULE3
                    term2_chr <= reg_wdata[HI_BYTE_LSB +: 8];
                end
                REG_OUT_INIT: init_chr <= reg_wdata[LO_BYTE_LSB +: 8]; // RULE9
                REG_EXT_DELAY: icd_ms <= reg_wdata[MSW-1:0]; // RULE9
                REG_EXT_IMM: imm_chr <= reg_wdata[LO_BYTE_LSB +: 8];
                REG_BLOCK: block_size <= reg_wdata[SZW-1:0]; // RULE2
                REG_HS_CHARS: begin
                    enq_chr <= reg_wdata[LO_BYTE_LSB +: 8]; // RULE2
                    ack_chr <= reg_wdata[HI_BYTE_LSB +: 8]; // RULE2
                end
                REG_BUF_SIZE: buf_size <= reg_wdata[SZW-1:0]; // RULE9
                REG_PRESET: begin
                    // Common values first; each preset below overrides what differs.
                    block_size <= DEF_BLOCK; // RULE15
                    buf_size <= DEF_BUF_SIZE; // RULE15
                    term1_chr <= CHR_CR; // RULE14
                    term2_chr <= CHR_NUL; // RULE15
                    turn_ms <= MS_ZERO;
                    icd_ms <= MS_ZERO;
                    trigger_chr <= CHR_NUL;
                    echo_chr <= CHR_NUL;
                    enq_chr <= CHR_NUL;
                    ack_chr <= CHR_NUL;
                    imm_chr <= CHR_NUL;
                    hs_mode <= HS_MODE_OFF; // RULE14
                    method <= sfch_method_t'(preset_val); // RULE10
                    unique case (sfch_method_t'(preset_val))
                        METH_XON: begin
                            turn_ms <= XON_TURN_MS; // RULE12
                            echo_chr <= CHR_LF; // RULE12
                            ack_chr <= CHR_DC1; // RULE12
                            icd_ms <= XON_ICD_MS; // RULE12
                            imm_chr <= CHR_DC3; // RULE12
                            hs_mode <= HS_MODE_ON; // RULE15
                        end
                        METH_ENQ: begin
                            trigger_chr <= CHR_DC1; // RULE13
                            echo_chr <= CHR_LF; // RULE13
                            enq_chr <= CHR_ENQ; // RULE13
                            ack_chr <= CHR_ACK; // RULE13
                            hs_mode <= HS_MODE_ON; // RULE15
                        end
                        METH_NONE, METH_HARD: begin
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Buffer fill level
    logic [SZW-1:0] fill;
    logic [SZW-1:0] free_space;
    logic enq_hit;
    logic fill_inc;
    logic fill_dec;

    assign enq_hit = rx_valid && method == METH_ENQ && enq_chr != CHR_NUL && rx_data == enq_chr; // RULE19 RULE1
    assign fill_inc = rx_valid && !echo_wait && !enq_hit && fill != buf_size;
    assign fill_dec = buf_consume && fill != '0;
    assign free_space = (buf_size > fill) ? buf_size - fill : '0;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fill <= '0;
        end else if (fill_inc && !fill_dec) begin
            fill <= fill + 1'b1;
        end else if (fill_dec && !fill_inc) begin
            fill <= fill - 1'b1;
        end
    end

    // ==========================================================
    // Hardwire line
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dtr <= 1'b1; // RULE4
        end else if (method != METH_HARD) begin
            dtr <= 1'b1; // RULE4
        end else if (free_space < block_size) begin
            dtr <= 1'b0; // RULE5
        end else if (free_space > block_size) begin
            dtr <= 1'b1; // RULE6
        end
    end

    // ==========================================================
    // Reply sequencer
    // A request that arrives while a reply is in progress is dropped; the host waits for each answer.
    sfch_state_t state;
    logic kind_ack;
    logic [2:0] step;
    logic [SZW-1:0] snap;
    logic tmr_start;
    logic [MSW:0] tmr_ms;
    logic tmr_expired;
    logic reply_done;
    logic trig_seen;
    logic cur_ok;
    logic [7:0] cur_chr;
    logic [SZW-1:0] place;
    logic [SZW-1:0] quo;

    assign trig_seen = rx_valid && rx_data == trigger_chr;

    sfch_ms_timer #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_timer (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .start(tmr_start),
        .ms(tmr_ms),
        .expired(tmr_expired)
    );

    // Reply characters: initiator, body, first and second terminator; zero entries are skipped.
    always_comb begin
        cur_ok = 1'b0;
        cur_chr = CHR_NUL;
        place = 14'h0001;
        quo = '0;
        unique case (step)
            3'h0: begin
                cur_chr = init_chr;
                cur_ok = init_chr != CHR_NUL;
            end
            3'h1, 3'h2, 3'h3, 3'h4, 3'h5: begin
                unique case (step)
                    3'h1: place = 14'h2710;
                    3'h2: place = 14'h03e8;
                    3'h3: place = 14'h0064;
                    3'h4: place = 14'h000a;
                    default: place = 14'h0001;
                endcase
                quo = snap / place;
                if (kind_ack) begin
                    cur_chr = ack_chr; // RULE20
                    cur_ok = step == STEP_FIRST_DIGIT && ack_chr != CHR_NUL;
                end else begin
                    cur_chr = CHR_DIGIT0 + 8'(quo % 14'h000a); // RULE8
                    cur_ok = snap >= place || place == 14'h0001;
                end
            end
            3'h6: begin
                cur_chr = term1_chr;
                cur_ok = term1_chr != CHR_NUL;
            end
            3'h7: begin
                cur_chr = term2_chr;
                cur_ok = term1_chr != CHR_NUL && term2_chr != CHR_NUL;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            kind_ack <= 1'b0;
            step <= 3'h0;
            snap <= '0;
            tmr_start <= 1'b0;
            tmr_ms <= '0;
            tx_data <= CHR_NUL;
            tx_valid <= 1'b0;
            reply_done <= 1'b0;
        end else begin
            tmr_start <= 1'b0;
            reply_done <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (enq_hit || free_query) begin
                        kind_ack <= enq_hit;
                        state <= (trigger_chr != CHR_NUL) ? ST_TRIG : ST_ROOM; // RULE17
                    end
                end
                ST_TRIG: begin
                    if (trig_seen) begin
                        state <= ST_ROOM; // RULE17
                    end
                end
                ST_ROOM: begin
                    if (!kind_ack || free_space >= block_size) begin // RULE20
                        snap <= free_space; // RULE8
                        step <= 3'h0;
                        tmr_start <= 1'b1;
                        tmr_ms <= {1'b0, turn_ms} + {1'b0, icd_ms}; // RULE16 RULE18
                        state <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (tmr_expired && !tmr_start) begin
                        state <= ST_PICK; // RULE16
                    end
                end
                ST_PICK: begin
                    if (cur_ok) begin
                        tx_data <= cur_chr;
                        tx_valid <= 1'b1;
                        state <= ST_SEND;
                    end else if (step == STEP_LAST) begin
                        reply_done <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        step <= step + 3'h1;
                    end
                end
                ST_SEND: begin
                    if (tx_ready) begin
                        tx_valid <= 1'b0;
                        if (step == STEP_LAST) begin
                            reply_done <= 1'b1;
                            state <= ST_IDLE;
                        end else begin
                            step <= step + 3'h1;
                            tmr_start <= 1'b1;
                            tmr_ms <= {1'b0, icd_ms}; // RULE18
                            state <= ST_DELAY;
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Echo suppression: after a reply the input is closed until the echo terminator arrives.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            echo_wait <= 1'b0;
        end else if (reply_done && echo_chr != CHR_NUL) begin
            echo_wait <= 1'b1;
        end else if (echo_wait && rx_valid && rx_data == echo_chr) begin
            echo_wait <= 1'b0;
        end
    end

    // ==========================================================
    // Register read-back
    logic [DW-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        unique case (reg_addr)
            REG_OUT_DELAY: rd_mux = DW'(turn_ms);
            REG_OUT_CHARS: rd_mux = {echo_chr, trigger_chr};
            REG_OUT_TERM: rd_mux = {term2_chr, term1_chr};
            REG_OUT_INIT: rd_mux = DW'(init_chr);
            REG_EXT_DELAY: rd_mux = DW'(icd_ms);
            REG_EXT_IMM: rd_mux = DW'(imm_chr);
            REG_BLOCK: rd_mux = DW'(block_size);
            REG_HS_CHARS: rd_mux = {ack_chr, enq_chr};
            REG_BUF_SIZE: rd_mux = DW'(buf_size);
            REG_PRESET: begin
                rd_mux[PRESET_VAL_LSB +: 2] = method;
                rd_mux[PRESET_MODE_LSB +: 2] = hs_mode;
            end
            REG_STATUS: begin
                rd_mux[STAT_DTR_BIT] = dtr;
                rd_mux[STAT_BUSY_BIT] = state != ST_IDLE;
                rd_mux[STAT_ECHO_BIT] = echo_wait;
            end
            REG_FREE: rd_mux = DW'(free_space); // RULE8
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

    // ==========================================================
    // Checks
    AST_DTR_OTHER_MODE: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE4
        method != METH_HARD |=> dtr) else $error("Line low outside hardwire mode.");
    AST_DTR_LOW: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE5
        method == METH_HARD && free_space < block_size |=> !dtr) else $error("Line not lowered.");
    AST_DTR_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE6
        method == METH_HARD && !dtr && free_space <= block_size |=> !dtr) else $error("Line raised early.");
    AST_NO_PARAM: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE11
        reg_wr && reg_addr == REG_PRESET && !reg_wdata[PRESET_PARAM_BIT] |=> method == METH_NONE && hs_mode == HS_MODE_OFF)
        else $error("Missing parameter did not select none.");
    AST_PRESET_XON: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE12
        reg_wr && reg_addr == REG_PRESET && preset_val == 2'h1
        |=> turn_ms == XON_TURN_MS && icd_ms == XON_ICD_MS && ack_chr == CHR_DC1 && imm_chr == CHR_DC3)
        else $error("Xon-Xoff preset values wrong.");
    AST_PRESET_ENQ: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE13
        reg_wr && reg_addr == REG_PRESET && preset_val == 2'h2
        |=> trigger_chr == CHR_DC1 && enq_chr == CHR_ENQ && ack_chr == CHR_ACK && icd_ms == MS_ZERO)
        else $error("Enquire preset values wrong.");
    AST_PRESET_COMMON: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE15
        reg_wr && reg_addr == REG_PRESET
        |=> block_size == DEF_BLOCK && buf_size == DEF_BUF_SIZE && term2_chr == CHR_NUL && term1_chr == CHR_CR)
        else $error("Common preset values wrong.");
    AST_BLOCK_CFG: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE2
        reg_wr && reg_addr == REG_BLOCK |=> block_size == $past(reg_wdata[SZW-1:0]))
        else $error("Block size not stored.");
    AST_TRIG_WAIT: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE17
        state == ST_TRIG && !trig_seen |=> state == ST_TRIG && !tx_valid) else $error("Reply before trigger.");
    AST_ROOM_WAIT: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE20
        state == ST_ROOM && kind_ack && free_space < block_size |=> state == ST_ROOM)
        else $error("Acknowledge without room.");
    AST_DELAY_QUIET: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE16
        state == ST_DELAY && !tmr_expired |=> !tx_valid [*2]) else $error("Character sent during delay.");

endmodule

/* File: src/sfch_pkg.sv */
// Constants and types shared by the serial flow-control handshake block.
// Assumes one 20 MHz system clock and a register port with 4-bit word addresses.
package sfch_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS = 1_000_000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Widths
    localparam int AW = 4;
    localparam int DW = 16;
    localparam int MSW = 14;
    localparam int SZW = 14;

    // ==========================================================
    // Register offsets
    localparam logic [AW-1:0] REG_OUT_DELAY = 4'h0;
    localparam logic [AW-1:0] REG_OUT_CHARS = 4'h1;
    localparam logic [AW-1:0] REG_OUT_TERM = 4'h2;
    localparam logic [AW-1:0] REG_OUT_INIT = 4'h3;
    localparam logic [AW-1:0] REG_EXT_DELAY = 4'h4;
    localparam logic [AW-1:0] REG_EXT_IMM = 4'h5;
    localparam logic [AW-1:0] REG_BLOCK = 4'h6;
    localparam logic [AW-1:0] REG_HS_CHARS = 4'h7;
    localparam logic [AW-1:0] REG_BUF_SIZE = 4'h8;
    localparam logic [AW-1:0] REG_PRESET = 4'h9;
    localparam logic [AW-1:0] REG_STATUS = 4'ha;
    localparam logic [AW-1:0] REG_FREE = 4'hb;

    // ==========================================================
    // Field positions
    localparam int LO_BYTE_LSB = 0;
    localparam int HI_BYTE_LSB = 8;
    localparam int PRESET_VAL_LSB = 0;
    localparam int PRESET_MODE_LSB = 2;
    localparam int PRESET_PARAM_BIT = 15;
    localparam int STAT_DTR_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_ECHO_BIT = 2;

    // ==========================================================
    // Character codes and preset values
    localparam logic [7:0] CHR_NUL = 8'h00;
    localparam logic [7:0] CHR_ENQ = 8'h05;
    localparam logic [7:0] CHR_ACK = 8'h06;
    localparam logic [7:0] CHR_LF = 8'h0a;
    localparam logic [7:0] CHR_CR = 8'h0d;
    localparam logic [7:0] CHR_DC1 = 8'h11;
    localparam logic [7:0] CHR_DC3 = 8'h13;
    localparam logic [7:0] CHR_DIGIT0 = 8'h30;
    localparam logic [MSW-1:0] XON_TURN_MS = 14'h0032;
    localparam logic [MSW-1:0] XON_ICD_MS = 14'h000a;
    localparam logic [MSW-1:0] MS_ZERO = 14'h0000;
    localparam logic [SZW-1:0] DEF_BLOCK = 14'h0050;
    localparam logic [SZW-1:0] DEF_BUF_SIZE = 14'h0400;
    localparam logic [1:0] HS_MODE_ON = 2'h2;
    localparam logic [1:0] HS_MODE_OFF = 2'h0;
    localparam logic [2:0] STEP_FIRST_DIGIT = 3'h1;
    localparam logic [2:0] STEP_TERM1 = 3'h6;
    localparam logic [2:0] STEP_LAST = 3'h7;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {METH_NONE, METH_XON, METH_ENQ, METH_HARD} sfch_method_t;
    typedef enum logic [2:0] {ST_IDLE, ST_TRIG, ST_ROOM, ST_DELAY, ST_PICK, ST_SEND} sfch_state_t;

endpackage

/* File: src/sfch_ms_timer.sv */
// Millisecond delay timer for the reply path of the handshake block.
// Assumes start is a one-cycle pulse; expired is low from the cycle after start until the count runs out.
`timescale 1ns/10ps
module sfch_ms_timer
    import sfch_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYC_PER_MS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Control
    input wire logic start,
    input wire logic [MSW:0] ms,
    output logic expired
);

    // ==========================================================
    // Counters
    logic [MSW:0] ms_left;
    logic [31:0] cyc;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ms_left <= '0;
            cyc <= '0;
        end else if (start) begin
            ms_left <= ms;
            cyc <= '0;
        end else if (ms_left != '0) begin
            if (cyc == 32'(CYCLES_PER_MS - 1)) begin
                cyc <= '0;
                ms_left <= ms_left - 1'b1;
            end else begin
                cyc <= cyc + 32'h0000_0001;
            end
        end
    end

    assign expired = (ms_left == '0);

endmodule

/* File: testbench/sfch_host_model.sv */
// Host computer model: takes reply characters from the block and keeps them in order.
// Assumes tx_valid holds tx_data until tx_ready is seen high on a rising edge.
`timescale 1ns/10ps
module sfch_host_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Reply link
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    // Pace control: high makes the host accept only every other cycle
    input wire logic slow
);
    logic [7:0] got [$];
    // ==========================================================
    // Acceptance
    // A slow host stalls on purpose so the block must hold its character.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= slow ? !tx_ready : 1'b1;
            if (tx_valid && tx_ready) begin
                got.push_back(tx_data);
            end
        end
    end
endmodule

/* File: testbench/tb_sfch_handshake.sv */
// Self-checking bench for the handshake block: presets, hardwire line, enquiry and free-space replies.
// Assumes the host model on the reply side and a shortened millisecond of 4 cycles.
`timescale 1ns/10ps
module tb_sfch_handshake;
    import sfch_pkg::*;
    localparam int CPM = 4;
    logic sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, rx_valid = 0, buf_consume = 0, free_query = 0, slow = 0;
    logic [AW-1:0] reg_addr = '0;
    logic [DW-1:0] reg_wdata = '0;
    logic [7:0] rx_data = '0;
    logic [DW-1:0] reg_rdata;
    logic [7:0] tx_data;
    logic tx_valid, tx_ready, dtr, echo_wait;
    int err_total = 0, num_checks = 0, lat;
    logic [AW-1:0] adr [6] = '{REG_OUT_DELAY, REG_OUT_CHARS, REG_HS_CHARS, REG_EXT_DELAY, REG_EXT_IMM, REG_PRESET};
    logic [15:0] tbl [4][6] = '{'{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000},
        '{16'h0032, 16'h0a00, 16'h1100, 16'h000a, 16'h0013, 16'h0009},
        '{16'h0000, 16'h0a11, 16'h0605, 16'h0000, 16'h0000, 16'h000a},
        '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0003}};
    sfch_handshake #(.CYCLES_PER_MS(CPM)) sfch_handshake_i (.sys_clk(sys_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_valid(rx_valid), .rx_data(rx_data), .buf_consume(buf_consume), .free_query(free_query),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .dtr(dtr), .echo_wait(echo_wait));
    sfch_host_model sfch_host_model_i (.sys_clk(sys_clk), .resetn(resetn), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));
    // ==========================================================
    // Access tasks
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
        @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge sys_clk) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [15:0] exp);
        @(posedge sys_clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge sys_clk) reg_rd <= 1'b0;
        #1 chk("reg_rdata", exp, reg_rdata);
    endtask
    task automatic rx(input logic [7:0] c);
        @(posedge sys_clk) {rx_data, rx_valid} <= {c, 1'b1};
        @(posedge sys_clk) rx_valid <= 1'b0;
    endtask
    task automatic consume(input int n);
        repeat (n) begin
            @(posedge sys_clk) buf_consume <= 1'b1;
            @(posedge sys_clk) buf_consume <= 1'b0;
        end
    endtask
    task automatic wait_chars(input int n);
        for (int i = 0; i < 400 && sfch_host_model_i.got.size() < n; i++) @(posedge sys_clk);
    endtask
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // Clock, reset and watchdog
    initial begin
        forever #25 sys_clk = !sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        complete_run();
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        #1 chk("dtr", 1, dtr);
        rd(REG_OUT_TERM, 16'h000d);
        rd(REG_BLOCK, 16'h0050);
        for (int v = 0; v < 4; v++) begin
            wr(REG_PRESET, 16'h8000 | 16'(v));
            for (int k = 0; k < 6; k++) rd(adr[k], tbl[v][k]);
            rd(REG_OUT_TERM, 16'h000d);
            rd(REG_BUF_SIZE, 16'h0400);
        end
        // Preset 3 is hardwire; a block size near the buffer size shows each threshold step.
        wr(REG_BLOCK, 16'h03fc);
        repeat (5) rx(8'h41);
        @(posedge sys_clk) #1 chk("dtr", 0, dtr);
        rd(REG_FREE, 16'h03fb);
        consume(1);
        @(posedge sys_clk) #1 chk("dtr", 0, dtr);
        consume(1);
        @(posedge sys_clk) #1 chk("dtr", 1, dtr);
        rd(4'hc, 16'h0000);
        wr(REG_FREE, 16'h0001);
        rd(REG_FREE, 16'h03fd);
        wr(REG_PRESET, 16'h0003);
        rd(REG_PRESET, 16'h0000);
        wr(REG_PRESET, 16'h8002);
        consume(8);
        rx(CHR_ENQ);
        repeat (10) @(posedge sys_clk);
        chk("replies", 0, 16'(sfch_host_model_i.got.size()));
        rx(CHR_DC1);
        wait_chars(2);
        chk("ack", 16'h0006, 16'(sfch_host_model_i.got[0]));
        chk("term", 16'h000d, 16'(sfch_host_model_i.got[1]));
        repeat (6) @(posedge sys_clk);
        #1 chk("echo_wait", 1, echo_wait);
        rx(CHR_LF);
        #1 chk("echo_wait", 0, echo_wait);
        repeat (80) rx(8'h41);
        rd(REG_FREE, 16'h03af);
        // Query with turnaround and intercharacter delay of one millisecond each and a slow host.
        wr(REG_OUT_CHARS, 16'h0000);
        wr(REG_OUT_DELAY, 16'h0001);
        wr(REG_EXT_DELAY, 16'h0001);
        wr(REG_OUT_INIT, 16'h0002);
        rd(REG_OUT_INIT, 16'h0002);
        consume(81);
        sfch_host_model_i.got.delete();
        @(posedge sys_clk) {free_query, slow} <= 2'b11;
        @(posedge sys_clk) free_query <= 1'b0;
        for (lat = 1; lat < 200 && !tx_valid; lat++) @(posedge sys_clk) #1;
        chk("delay_met", 1, 16'(lat >= 2 * CPM && lat < 200));
        wait_chars(6);
        foreach (tbl[0][k]) chk("answer", 16'({8'h02, "1024", CHR_CR} >> (8 * (5 - k))) & 16'h00ff,
            16'(sfch_host_model_i.got[k]));
        complete_run();
    end
endmodule
